/* File: rtl/nvm_port_pkg.sv */
// Shared constants for the parallel nonvolatile programming port.
package nvm_port_pkg;
  // ****************************************
  // Action select codes and commands
  // ****************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_READ_FUSE  = 8'h04;
  localparam logic [7:0] CMD_READ_ID    = 8'h08;
  localparam logic [7:0] CMD_WR_FLASH   = 8'h10;
  localparam logic [7:0] CMD_WR_EEPROM  = 8'h11;
  localparam logic [7:0] CMD_WR_FUSE_HI = 8'h40;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
  // ****************************************
  // Geometry and timing
  // ****************************************
  localparam int FLASH_PAGE_WORDS = 16;
  localparam int FLASH_PAGES      = 64;
  localparam int EE_PAGE_BYTES    = 4;
  localparam int EE_PAGES         = 32;
  localparam int CLK_HZ           = 20000000;
  localparam int WRITE_TIME_US    = 4000;
  localparam int ERASE_TIME_US    = 8000;
  localparam int WRITE_CYCLES     = WRITE_TIME_US * (CLK_HZ / 1000000);
  localparam int ERASE_CYCLES     = ERASE_TIME_US * (CLK_HZ / 1000000);
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [7:0] FUSE_LO_RESET  = 8'hf0; // Neutral default.
  localparam logic [7:0] FUSE_HI_RESET  = 8'h0f; // Neutral default.
  localparam logic [7:0] LOCK_RESET     = 8'hff;
  localparam logic [7:0] ID_BYTE0       = 8'h5a; // Arbitrary value.
  localparam logic [7:0] ID_BYTE1       = 8'ha5; // Arbitrary value.
  localparam logic [7:0] ID_BYTE2       = 8'h3c; // Arbitrary value.
  localparam logic [7:0] CAL_RESET      = 8'h80;
  localparam logic [7:0] STROBE_GAP     = 8'h04;
  localparam int         BUSY_WAIT_MAX  = 20;
endpackage

/* File: rtl/nvm_port_if.sv */
// Pin bundle between the programmer and the programming port.
`timescale 1ns/1ps
interface nvm_port_if;
  logic       action_select_hi;
  logic       action_select_lo;
  logic       byte_select_one;
  logic       byte_select_two;
  logic       load_strobe;
  logic       write_n;
  logic       out_enable_n;
  logic       ready_flag;
  logic [7:0] data_from_prog;
  logic       data_prog_oe;
  logic [7:0] data_from_dev;
  logic       data_dev_oe;
  wire  [7:0] data_bus = data_dev_oe ? data_from_dev : data_from_prog;

  modport device (
    input  action_select_hi, action_select_lo, byte_select_one, byte_select_two,
    input  load_strobe, write_n, out_enable_n, data_bus,
    output ready_flag, data_from_dev, data_dev_oe
  );
  modport programmer (
    output action_select_hi, action_select_lo, byte_select_one, byte_select_two,
    output load_strobe, write_n, out_enable_n, data_from_prog, data_prog_oe,
    input  ready_flag, data_bus
  );
endinterface

/* File: rtl/nvm_port_device.sv */
// Device end: command, address and data latches, page memories and self-timed writes.
`timescale 1ns/1ps
// Contract
// RULE1: Select 10 with strobe loads command.
// RULE2: Select 00 loads address low or high.
// RULE3: Select 01 loads data low byte.
// RULE4: Byte select one high loads high byte.
// RULE5: Programmer repeats loads to fill page.
// RULE6: Low address bits pick word, upper page.
// RULE7: Write strobe programs flash page, busy low.
// RULE8: Programmer waits ready before next page.
// RULE9: No-operation command clears write signals.
// RULE10: Command 11 selects EEPROM page writing.
// RULE11: Write strobe programs EEPROM page, busy.
// RULE12: Command 40 writes fuse high bits.
// RULE13: Fuse data zero programs, one erases.
// RULE14: Lock bits cleared only by erase.
// RULE15: Command 04 reads fuse and lock.
// RULE16: Command 08 reads identification bytes.
// RULE17: Byte select one reads calibration byte.
// RULE18: Command 10 selects flash writing.
// RULE19: Command 80 with write erases chip.
// RULE20: Output enable high releases data bus.
// RULE21: Last command stays until replaced.
module nvm_port_device #(
  parameter int WRITE_CYC = nvm_port_pkg::WRITE_CYCLES,
  parameter int ERASE_CYC = nvm_port_pkg::ERASE_CYCLES,
  parameter int PG_WORDS  = nvm_port_pkg::FLASH_PAGE_WORDS,
  parameter int PAGES     = nvm_port_pkg::FLASH_PAGES,
  parameter int EE_BYTES  = nvm_port_pkg::EE_PAGE_BYTES,
  parameter int EE_PAGES  = nvm_port_pkg::EE_PAGES
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  nvm_port_if.device      pins,
  output logic            busy,
  output logic [7:0]      command
);
  localparam int WB   = $clog2(PG_WORDS);
  localparam int EB   = $clog2(EE_BYTES);
  localparam int NW   = PG_WORDS * PAGES;
  localparam int NE   = EE_BYTES * EE_PAGES;
  localparam int AW   = $clog2(NW);
  localparam int EAW  = $clog2(NE);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [14:0] sync1_ff;
  logic [14:0] sync2_ff;
  logic        ld_prev_ff;
  logic        wr_prev_ff;
  wire  [14:0] raw_pins = {pins.action_select_hi, pins.action_select_lo,
                           pins.byte_select_one, pins.byte_select_two,
                           pins.load_strobe, pins.write_n, pins.out_enable_n,
                           pins.data_bus};

  // Two stages on every pin; only the second stage feeds logic.
  always_ff @(posedge clk) begin
    sync1_ff <= raw_pins;
    sync2_ff <= sync1_ff;
  end

  wire [1:0] act     = sync2_ff[14:13];
  wire       bs1     = sync2_ff[12];
  wire       bs2     = sync2_ff[11];
  wire       ld      = sync2_ff[10];
  wire       wr_n    = sync2_ff[9];
  wire       oe_n    = sync2_ff[8];
  wire [7:0] din     = sync2_ff[7:0];
  // Controls are sampled at the load strobe's rising edge, so the setup is met.
  wire       ld_rise = ld & ~ld_prev_ff;
  wire       wr_fall = ~wr_n & wr_prev_ff;

  // ****************************************
  // Latches and memories
  // ****************************************
  logic [7:0]  cmd_ff;
  logic [7:0]  addr_lo_ff;
  logic [7:0]  addr_hi_ff;
  logic [7:0]  data_lo_ff;
  logic [15:0] fbuf [PG_WORDS];
  logic [7:0]  ebuf [EE_BYTES];
  logic [15:0] flash [NW];
  logic [7:0]  eeprom [NE];
  logic [7:0]  fuse_lo_ff;
  logic [7:0]  fuse_hi_ff;
  logic [7:0]  lock_ff;
  logic [7:0]  cal_ff;
  logic [31:0] tmr_ff;
  logic        busy_ff;
  logic        armed_ff;
  logic [7:0]  dout_ff;
  logic        doe_ff;

  // RULE1: command strobe decode
  wire ld_cmd  = ld_rise & (act == nvm_port_pkg::ACT_CMD);
  // RULE2: address strobe decode
  wire ld_addr = ld_rise & (act == nvm_port_pkg::ACT_ADDR);
  // RULE3: data strobe decode
  wire ld_data = ld_rise & (act == nvm_port_pkg::ACT_DATA);
  // RULE6: word and page split
  wire [WB-1:0] word_sel = addr_lo_ff[WB-1:0];
  wire [15:0]   full_addr = {addr_hi_ff, addr_lo_ff};
  wire [AW-WB-1:0] page_sel = full_addr[AW-1:WB];
  wire [EB-1:0] ebyte_sel = addr_lo_ff[EB-1:0];
  wire [EAW-EB-1:0] epage_sel = addr_lo_ff[EAW-1:EB];
  // RULE7: flash write start gate
  // RULE11: same gate starts EEPROM
  wire start_wr = wr_fall & ~busy_ff & ~bs1 & armed_ff;
  wire start_fuse = wr_fall & ~busy_ff & bs1 & ~bs2 & armed_ff &
                    (cmd_ff == nvm_port_pkg::CMD_WR_FUSE_HI);

  // Edge history and command latch; reset leaves a no-operation command.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ld_prev_ff <= 1'b0;
      wr_prev_ff <= 1'b1;
      cmd_ff     <= nvm_port_pkg::CMD_NOP;
      armed_ff   <= 1'b0;
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      data_lo_ff <= 8'h00;
    end else begin
      ld_prev_ff <= ld;
      wr_prev_ff <= wr_n;
      // RULE21: command held until reload
      if (ld_cmd && !busy_ff) begin
        cmd_ff   <= din;
        // RULE9: no-operation disarms writes
        armed_ff <= (din != nvm_port_pkg::CMD_NOP);
      end
      if (ld_addr && !bs1)
        addr_lo_ff <= din;
      if (ld_addr && bs1)
        addr_hi_ff <= din;
      if (ld_data && !bs1)
        data_lo_ff <= din;
    end
  end

  // Page buffers fill from data strobes; the low byte is kept until the high one arrives.
  always_ff @(posedge clk) begin
    if (ld_data && cmd_ff == nvm_port_pkg::CMD_WR_FLASH) begin
      // RULE4: high byte completes word
      if (bs1)
        fbuf[word_sel] <= {din, data_lo_ff};
      else
        fbuf[word_sel][7:0] <= din;
    end
    // RULE10: EEPROM buffer loads
    if (ld_data && !bs1 && cmd_ff == nvm_port_pkg::CMD_WR_EEPROM)
      ebuf[ebyte_sel] <= din;
  end

  // ****************************************
  // Self-timed programming
  // ****************************************
  // Arrays are updated at the start; busy then models the array write time.
  always_ff @(posedge clk) begin
    if (start_wr && cmd_ff == nvm_port_pkg::CMD_WR_FLASH) begin
      // RULE18: flash page commit
      for (int i = 0; i < PG_WORDS; i++)
        flash[{page_sel, i[WB-1:0]}] <= fbuf[i];
    end
    if (start_wr && cmd_ff == nvm_port_pkg::CMD_WR_EEPROM) begin
      for (int i = 0; i < EE_BYTES; i++)
        eeprom[{epage_sel, i[EB-1:0]}] <= ebuf[i];
    end
    if (start_wr && cmd_ff == nvm_port_pkg::CMD_CHIP_ERASE) begin
      // RULE19: erase both arrays
      for (int i = 0; i < NW; i++)
        flash[i] <= {nvm_port_pkg::ERASED_BYTE, nvm_port_pkg::ERASED_BYTE};
      for (int i = 0; i < NE; i++)
        eeprom[i] <= nvm_port_pkg::ERASED_BYTE;
    end
  end

  // Fuses, lock and the busy timer; only erase may return lock bits to one.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      busy_ff <= 1'b0;
      tmr_ff  <= 32'h0;
    end else if (busy_ff) begin
      if (tmr_ff == 32'h0)
        busy_ff <= 1'b0;
      else
        tmr_ff <= tmr_ff - 32'h1;
    end else if (start_fuse || (start_wr && (cmd_ff == nvm_port_pkg::CMD_WR_FLASH ||
                 cmd_ff == nvm_port_pkg::CMD_WR_EEPROM))) begin
      busy_ff <= 1'b1;
      tmr_ff  <= 32'(WRITE_CYC - 1);
    end else if (start_wr && cmd_ff == nvm_port_pkg::CMD_CHIP_ERASE) begin
      busy_ff <= 1'b1;
      tmr_ff  <= 32'(ERASE_CYC - 1);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fuse_lo_ff <= nvm_port_pkg::FUSE_LO_RESET;
      fuse_hi_ff <= nvm_port_pkg::FUSE_HI_RESET;
      lock_ff    <= nvm_port_pkg::LOCK_RESET;
      cal_ff     <= nvm_port_pkg::CAL_RESET;
    end else begin
      // RULE12: fuse high write
      // RULE13: zero programs, one erases
      if (start_fuse)
        fuse_hi_ff <= data_lo_ff;
      // RULE14: lock cleared by erase
      if (start_wr && cmd_ff == nvm_port_pkg::CMD_CHIP_ERASE)
        lock_ff <= nvm_port_pkg::LOCK_RESET;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  logic [7:0] rd_val;
  // RULE15: fuse and lock selection
  // RULE16: identification byte selection
  // RULE17: calibration byte selection
  always_comb begin
    rd_val = 8'h00;
    if (cmd_ff == nvm_port_pkg::CMD_READ_FUSE) begin
      case ({bs2, bs1})
        2'h0:    rd_val = fuse_lo_ff;
        2'h3:    rd_val = fuse_hi_ff;
        2'h1:    rd_val = lock_ff;
        default: rd_val = 8'h00;
      endcase
    end else if (cmd_ff == nvm_port_pkg::CMD_READ_ID) begin
      if (bs1)
        rd_val = cal_ff;
      else if (addr_lo_ff == 8'h00)
        rd_val = nvm_port_pkg::ID_BYTE0;
      else if (addr_lo_ff == 8'h01)
        rd_val = nvm_port_pkg::ID_BYTE1;
      else if (addr_lo_ff == 8'h02)
        rd_val = nvm_port_pkg::ID_BYTE2;
    end
  end

  wire rd_cmd = (cmd_ff == nvm_port_pkg::CMD_READ_FUSE) ||
                (cmd_ff == nvm_port_pkg::CMD_READ_ID);

  // RULE20: release bus unless enabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dout_ff <= 8'h00;
      doe_ff  <= 1'b0;
    end else begin
      dout_ff <= rd_val;
      doe_ff  <= ~oe_n & rd_cmd;
    end
  end

  // RULE7: ready flag low while busy
  assign pins.ready_flag    = ~busy_ff;
  assign pins.data_from_dev = dout_ff;
  assign pins.data_dev_oe   = doe_ff;
  assign busy               = busy_ff;
  assign command            = cmd_ff;
endmodule

/* File: rtl/nvm_port_programmer.sv */
// Programmer end: turns user requests into pin sequences on the programming port.
`timescale 1ns/1ps
module nvm_port_programmer (
  input  wire logic       clk,
  input  wire logic       resetn,
  nvm_port_if.programmer  pins,
  input  wire logic       req_valid,
  input  wire logic [2:0] req_kind,
  input  wire logic [1:0] req_sel,
  input  wire logic [7:0] req_data,
  output logic            req_ready,
  output logic [7:0]      rd_data,
  output logic            rd_valid
);
  // Kinds: 0 load, 1 write pulse, 2 read, 3 wait ready, 4 load with byte select one high.
  typedef enum {ST_IDLE, ST_SETUP, ST_HIGH, ST_HOLD, ST_WAIT} state_t;
  state_t     st_ff;
  logic [7:0] cnt_ff;
  logic [2:0] kind_ff;
  logic       rdy1_ff;
  logic       rdy2_ff;
  logic [7:0] dat1_ff;
  logic [7:0] dat2_ff;
  logic       asel_hi_ff, asel_lo_ff, bs1_ff, bs2_ff, ld_ff, wr_n_ff, oe_n_ff, doe_ff;
  logic [7:0] dout_ff;
  logic       req_ready_ff;
  logic [7:0] rd_data_ff;
  logic       rd_valid_ff;

  // Pins from the device pass two flops before use.
  always_ff @(posedge clk) begin
    rdy1_ff <= pins.ready_flag;
    rdy2_ff <= rdy1_ff;
    dat1_ff <= pins.data_bus;
    dat2_ff <= dat1_ff;
  end

  wire cnt_done = (cnt_ff == 8'h00);
  // Loads take byte select one from the kind, so any data or address byte can be sent.
  wire is_load  = (req_kind[1:0] == 2'h0);

  // Each request except wait ready walks setup, active, hold with a fixed gap of strobe cycles; wait ready goes from setup straight to wait.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_ff <= ST_IDLE; cnt_ff <= 8'h00; kind_ff <= 3'h0;
      asel_hi_ff <= 1'b0; asel_lo_ff <= 1'b0; bs1_ff <= 1'b0; bs2_ff <= 1'b0;
      ld_ff <= 1'b0; wr_n_ff <= 1'b1; oe_n_ff <= 1'b1; doe_ff <= 1'b0;
      dout_ff <= 8'h00; req_ready_ff <= 1'b1; rd_data_ff <= 8'h00; rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= 1'b0;
      if (!cnt_done)
        cnt_ff <= cnt_ff - 8'h01;
      case (st_ff)
        ST_IDLE: begin
          if (req_valid) begin
            kind_ff <= {1'b0, req_kind[1:0]};
            {asel_hi_ff, asel_lo_ff} <= req_sel;
            bs1_ff <= is_load ? req_kind[2] : req_data[0];
            bs2_ff <= ~is_load & req_data[1];
            dout_ff <= req_data;
            doe_ff <= is_load;
            req_ready_ff <= 1'b0;
            cnt_ff <= nvm_port_pkg::STROBE_GAP;
            st_ff <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          // The strobe rises only after selects and data have stood for the gap.
          if (cnt_done) begin
            if (kind_ff == 3'h0) ld_ff <= 1'b1;
            if (kind_ff == 3'h1) wr_n_ff <= 1'b0;
            if (kind_ff == 3'h2) oe_n_ff <= 1'b0;
            cnt_ff <= nvm_port_pkg::STROBE_GAP;
            st_ff <= (kind_ff == 3'h3) ? ST_WAIT : ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_done) begin
            ld_ff <= 1'b0; wr_n_ff <= 1'b1; oe_n_ff <= 1'b1;
            cnt_ff <= nvm_port_pkg::STROBE_GAP;
            st_ff <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_done) begin
            // Read data is taken late: the device answers three clocks after the
            // enable and the return path adds two more, so the strobe end is too early.
            if (kind_ff == 3'h2) begin
              rd_data_ff <= dat2_ff;
              rd_valid_ff <= 1'b1;
            end
            doe_ff <= 1'b0;
            st_ff <= (kind_ff == 3'h1) ? ST_WAIT : ST_IDLE;
            req_ready_ff <= (kind_ff != 3'h1);
          end
        end
        ST_WAIT: begin
          // RULE8: hold off until ready
          if (cnt_done && rdy2_ff) begin
            req_ready_ff <= 1'b1;
            st_ff <= ST_IDLE;
          end
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  assign pins.action_select_hi = asel_hi_ff;
  assign pins.action_select_lo = asel_lo_ff;
  assign pins.byte_select_one  = bs1_ff;
  assign pins.byte_select_two  = bs2_ff;
  assign pins.load_strobe      = ld_ff;
  assign pins.write_n          = wr_n_ff;
  assign pins.out_enable_n     = oe_n_ff;
  assign pins.data_from_prog   = dout_ff;
  assign pins.data_prog_oe     = doe_ff;
  assign req_ready             = req_ready_ff;
  assign rd_data               = rd_data_ff;
  assign rd_valid              = rd_valid_ff;
endmodule

/* File: sim/nvm_port_props.sv */
// Concurrent checks on the pins between programmer and device.
`timescale 1ns/1ps
module nvm_port_props #(
  parameter int W = 20,
  parameter int E = 40
) (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       byte_select_one,
  input wire logic       byte_select_two,
  input wire logic       action_select_hi,
  input wire logic       action_select_lo,
  input wire logic       load_strobe,
  input wire logic       write_n,
  input wire logic       out_enable_n,
  input wire logic       ready_flag,
  input wire logic [7:0] data_from_prog,
  input wire logic       data_prog_oe,
  input wire logic       data_dev_oe
);
  // ****************************************
  // Busy length counter
  // ****************************************
  int unsigned low_ff;
  int unsigned nxt_low;
  // Counting sampled busy cycles lets the release edge be checked exactly.
  assign nxt_low = ready_flag ? 0 : low_ff + 1;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_ff <= 0;
    end else begin
      low_ff <= nxt_low;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence load_pulse_s;
    load_strobe [*5] ##1 !load_strobe;
  endsequence
  sequence write_end_s;
    ##[1:8] write_n;
  endsequence
  // Both ends must come out of reset idle, with the device not driving the data bus.
  reset_idle_a: assert property (!$past(resetn) |-> ready_flag && !load_strobe && write_n && !data_dev_oe)
    else $error("pins not idle after reset");
  strobe_width_a: assert property ($rose(load_strobe) |-> load_pulse_s)
    else $error("load strobe pulse has wrong width");
  load_hold_a: assert property (load_strobe && $past(load_strobe) |->
    $stable({action_select_hi, action_select_lo, byte_select_one, data_from_prog}))
    else $error("select or data moved during load strobe");
  write_pulse_a: assert property ($fell(write_n) |-> write_end_s)
    else $error("write pulse not ended in time");
  write_hold_a: assert property (!write_n && !$past(write_n) |->
    $stable({byte_select_one, byte_select_two}))
    else $error("byte selects moved during write pulse");
  busy_cause_a: assert property ($fell(ready_flag) |-> !$past(write_n))
    else $error("busy began without a write pulse");
  busy_length_a: assert property ($rose(ready_flag) |-> low_ff == W || low_ff == E)
    else $error("busy period has wrong length");
  wait_ready_a: assert property ($rose(load_strobe) || $fell(write_n) |-> ready_flag)
    else $error("programmer acted while device busy");
  bus_release_a: assert property (out_enable_n [*4] |-> !data_dev_oe)
    else $error("device drives bus with output enable high");
  no_clash_a: assert property (!(data_dev_oe && data_prog_oe))
    else $error("both ends drive the data bus");
  drive_cause_a: assert property ($rose(data_dev_oe) |-> !out_enable_n && !$past(out_enable_n))
    else $error("device drive without output enable");
endmodule

/* File: sim/parallel_nvm_programming_port_bench.sv */
// Self-checking bench joining the programmer end to the device end.
`timescale 1ns/1ps
module parallel_nvm_programming_port_bench;
  localparam int WC = 20;
  localparam int EC = 40;
  logic       clk;
  logic       resetn;
  logic       req_valid;
  logic [2:0] req_kind;
  logic [1:0] req_sel;
  logic [7:0] req_data;
  logic       req_ready;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       busy;
  logic [7:0] command;
  logic [7:0] got;
  logic [7:0] v;
  logic [7:0] fuse_v;
  logic       prev_rdy = 1'b1;
  int         err_total;
  int         check_count;
  int         run_len = 0;
  int         last_low = 0;
  int         falls = 0;
  int         f0;
  logic [7:0] cmds [7] = '{nvm_port_pkg::CMD_NOP, nvm_port_pkg::CMD_READ_FUSE,
    nvm_port_pkg::CMD_READ_ID, nvm_port_pkg::CMD_WR_FLASH, nvm_port_pkg::CMD_WR_EEPROM,
    nvm_port_pkg::CMD_WR_FUSE_HI, nvm_port_pkg::CMD_CHIP_ERASE};
  nvm_port_if u_nvm_port_if ();
  nvm_port_device #(.WRITE_CYC(WC), .ERASE_CYC(EC)) u_nvm_port_device (.clk(clk),
    .resetn(resetn), .pins(u_nvm_port_if.device), .busy(busy), .command(command));
  nvm_port_programmer u_nvm_port_programmer (.clk(clk), .resetn(resetn),
    .pins(u_nvm_port_if.programmer), .req_valid(req_valid), .req_kind(req_kind),
    .req_sel(req_sel), .req_data(req_data), .req_ready(req_ready), .rd_data(rd_data),
    .rd_valid(rd_valid));
  nvm_port_props #(.W(WC), .E(EC)) u_nvm_port_props (.clk(clk), .resetn(resetn),
    .byte_select_one(u_nvm_port_if.byte_select_one),
    .byte_select_two(u_nvm_port_if.byte_select_two),
    .action_select_hi(u_nvm_port_if.action_select_hi),
    .action_select_lo(u_nvm_port_if.action_select_lo),
    .load_strobe(u_nvm_port_if.load_strobe), .write_n(u_nvm_port_if.write_n),
    .out_enable_n(u_nvm_port_if.out_enable_n), .ready_flag(u_nvm_port_if.ready_flag),
    .data_from_prog(u_nvm_port_if.data_from_prog), .data_prog_oe(u_nvm_port_if.data_prog_oe),
    .data_dev_oe(u_nvm_port_if.data_dev_oe));
  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Tracks busy starts and the length of the last busy period.
  always @(posedge clk) begin
    prev_rdy <= u_nvm_port_if.ready_flag;
    if (prev_rdy && !u_nvm_port_if.ready_flag) falls <= falls + 1;
    if (!u_nvm_port_if.ready_flag) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_low <= run_len;
      run_len <= 0;
    end
  end
  // Identification byte expected for a low address.
  function automatic logic [7:0] exp_id(input int a);
    case (a)
      0:       return nvm_port_pkg::ID_BYTE0;
      1:       return nvm_port_pkg::ID_BYTE1;
      default: return nvm_port_pkg::ID_BYTE2;
    endcase
  endfunction
  task automatic wrap_up();
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // One request; kind 0 loads with byte select one low, kind 4 with it high, other kinds take the selects from d.
  task automatic op(input logic [2:0] k, input logic [1:0] s, input logic [7:0] d);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_kind <= k;
    req_sel <= s;
    req_data <= d;
    @(posedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    req_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      if (rd_valid === 1'b1) got = rd_data;
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) check(16'h0, 16'h1, "request hang");
  endtask
  task automatic cmd(input logic [7:0] c);
    op(3'h0, nvm_port_pkg::ACT_CMD, c);
    check(command, c, "command latch");
  endtask
  task automatic rd(input logic [7:0] bs, input logic [7:0] exp);
    got = 'x;
    op(3'h2, 2'h0, bs);
    check(got, exp, "read byte");
    check(u_nvm_port_if.data_dev_oe, 1'b0, "bus released");
  endtask
  // A stale busy length can still pass the length check, but the start count check then fails.
  task automatic wr(input logic [7:0] bs, input int dn, input int len);
    f0 = falls;
    op(3'h1, 2'h0, bs);
    check(16'(falls - f0), 16'(dn), "busy starts");
    if (dn != 0) check(16'(last_low), 16'(len), "busy length");
  endtask
  // Reset, then every command through its documented sequence.
  initial begin
    void'($urandom(97));
    resetn = 1'b0;
    req_valid = 1'b0;
    req_kind = 3'h0;
    req_sel = 2'h0;
    req_data = 8'h00;
    err_total = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check({busy, u_nvm_port_if.ready_flag, req_ready}, 3'h3, "reset state");
    check(command, nvm_port_pkg::CMD_NOP, "reset command");
    cmd(nvm_port_pkg::CMD_READ_FUSE);
    rd(8'h00, nvm_port_pkg::FUSE_LO_RESET);
    rd(8'h03, nvm_port_pkg::FUSE_HI_RESET);
    rd(8'h01, nvm_port_pkg::LOCK_RESET);
    cmd(nvm_port_pkg::CMD_READ_ID);
    for (int a = 0; a < 3; a++) begin
      op(3'h0, nvm_port_pkg::ACT_ADDR, 8'(a));
      rd(8'h00, exp_id(a));
    end
    rd(8'h01, nvm_port_pkg::CAL_RESET);
    fuse_v = 8'($urandom);
    cmd(nvm_port_pkg::CMD_WR_FUSE_HI);
    wr(8'h00, 0, 0);
    op(3'h0, nvm_port_pkg::ACT_DATA, fuse_v);
    wr(8'h01, 1, WC);
    cmd(nvm_port_pkg::CMD_READ_FUSE);
    rd(8'h03, fuse_v);
    rd(8'h01, nvm_port_pkg::LOCK_RESET);
    cmd(nvm_port_pkg::CMD_WR_FLASH);
    for (int i = 0; i < nvm_port_pkg::FLASH_PAGE_WORDS; i++) begin
      v = 8'($urandom);
      op(3'h0, nvm_port_pkg::ACT_ADDR, 8'(i));
      op(3'h0, nvm_port_pkg::ACT_DATA, v);
      op(3'h4, nvm_port_pkg::ACT_DATA, ~v);
    end
    op(3'h4, nvm_port_pkg::ACT_ADDR, 8'h01);
    wr(8'h00, 1, WC);
    wr(8'h00, 1, WC);
    cmd(nvm_port_pkg::CMD_NOP);
    wr(8'h00, 0, 0);
    cmd(nvm_port_pkg::CMD_WR_EEPROM);
    op(3'h0, nvm_port_pkg::ACT_ADDR, 8'h04);
    op(3'h0, nvm_port_pkg::ACT_DATA, 8'($urandom));
    wr(8'h01, 0, 0);
    wr(8'h00, 1, WC);
    cmd(nvm_port_pkg::CMD_CHIP_ERASE);
    wr(8'h00, 1, EC);
    cmd(nvm_port_pkg::CMD_READ_FUSE);
    rd(8'h01, nvm_port_pkg::LOCK_RESET);
    rd(8'h03, fuse_v);
    f0 = falls;
    repeat (8) cmd(cmds[$urandom_range(6, 0)]);
    check(16'(falls - f0), 16'h0, "busy without write");
    wrap_up();
  end
  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule
